// >>> lpd_power_defs.vh
// constants for the lcd power-mode and partial-display controller
`ifndef LPD_POWER_DEFS_VH
`define LPD_POWER_DEFS_VH
// ----------------------------------------
// clocking and timing
// ----------------------------------------
`define LPD_CLK_HZ 100000000
`define LPD_OSC_HZ 50000
`define LPD_OSC_DIV_W 12
`define LPD_OSC_SETTLE 8'h10
// ----------------------------------------
// register word addresses
// ----------------------------------------
`define LPD_ADDR_W 4
`define LPD_DATA_W 8
`define LPD_A_CTRL 4'h0
`define LPD_A_POWER 4'h1
`define LPD_A_OSC 4'h2
`define LPD_A_KEYEN 4'h3
`define LPD_A_STATUS 4'h4
`define LPD_A_MASK 4'h5
`define LPD_A_STATE 4'h6
`define LPD_A_DRIVE 4'h7
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define LPD_CTRL_RST 8'h14
`define LPD_POWER_RST 8'h04
`define LPD_DRIVE_RST 8'h00
`define LPD_P_SLEEP 0
`define LPD_P_STBY 1
`define LPD_P_SUPPLY 2
`define LPD_P_CENTER 6
`define LPD_S_KEY 0
`define LPD_S_FRAME 1
`define LPD_S_OSC 2
`define LPD_NEV 3
// ----------------------------------------
// duty codes, scan lengths, row timing
// ----------------------------------------
`define LPD_DUTY_34 3'h4
`define LPD_DUTY_18 3'h2
`define LPD_DUTY_10 3'h1
`define LPD_SLOTS_34 6'h22
`define LPD_SLOTS_18 6'h12
`define LPD_SLOTS_10 6'h0A
`define LPD_ROWCLK_34 7'h14
`define LPD_ROWCLK_18 7'h26
`define LPD_ROWCLK_10 7'h44
`define LPD_PANEL_ROWS 6'h20
`define LPD_ROWS 40
`define LPD_ICONS 2
`define LPD_MODE_RUN 2'h0
`define LPD_MODE_SLEEP 2'h1
`define LPD_MODE_STBY 2'h2
`endif

// >>> lpd_power_ctl.v
// power-mode sequencing and partial-display row drive for the lcd controller
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// ----------------------------------------
`include "lpd_power_defs.vh"

module lpd_power_ctl #(
  parameter OSC_DIV = `LPD_CLK_HZ / `LPD_OSC_HZ
) (
  input wire clock,
  input wire reset,
  input wire [`LPD_ADDR_W-1:0] regAddr,
  input wire [`LPD_DATA_W-1:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [`LPD_DATA_W-1:0] regRdData,
  input wire keyHit,
  output reg keyIrq_n,
  output reg irq,
  output reg keyScanRun,
  output reg oscRunning,
  output reg lcdSupplyOn,
  output reg columnDriveOn,
  output reg [`LPD_ROWS-1:0] rowDriveOn,
  output reg [`LPD_ROWS-1:0] rowSelect,
  output reg [`LPD_ICONS-1:0] iconRowDriveOn,
  output reg [`LPD_ICONS-1:0] iconRowSelect,
  output reg [1:0] boostLevel,
  output reg [4:0] contrastLevel,
  output reg [2:0] biasSelect,
  output reg frameStart
);

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  reg [`LPD_DATA_W-1:0] ctrl_r; // duty, bias, centering
  reg [`LPD_DATA_W-1:0] power_r; // sleep, standby, supply
  reg [`LPD_DATA_W-1:0] drive_r; // boost and contrast
  reg keyIrqEn_r; // key interrupt enable
  reg [`LPD_NEV-1:0] status_r; // sticky events
  reg [`LPD_NEV-1:0] mask_r; // interrupt mask
  reg [`LPD_NEV-1:0] status_nxt;
  reg [`LPD_DATA_W-1:0] rdData_nxt;

  // ----------------------------------------
  // oscillator model and mode state
  // ----------------------------------------
  reg oscRun_r; // internal r-c oscillator running
  reg [`LPD_OSC_DIV_W-1:0] oscDiv_r; // divider to oscillator rate
  reg [7:0] settle_r; // ticks since restart
  reg oscStable_r; // settle count reached
  reg oscTick; // one-cycle oscillator enable
  wire [2:0] dutySel;
  wire centerEn;
  wire sleepReq;
  wire stbyReq;
  wire sleepEff;
  wire dispActive;
  wire wrAllowed;
  wire oscStartCmd;

  assign dutySel = ctrl_r[2:0];
  assign centerEn = ctrl_r[`LPD_P_CENTER];
  assign sleepReq = power_r[`LPD_P_SLEEP];
  assign stbyReq = power_r[`LPD_P_STBY];
  // standby is the superset, so it masks sleep
  assign sleepEff = sleepReq & ~stbyReq;
  // display runs only with neither low-power mode and a live clock
  assign dispActive = ~sleepReq & ~stbyReq & oscRun_r;
  // while the oscillator is halted in standby, only two addresses listen
  assign wrAllowed = ~(stbyReq & ~oscRun_r);
  assign oscStartCmd = regWrite & (regAddr == `LPD_A_OSC) & regWrData[0];

  // ----------------------------------------
  // scan timing
  // ----------------------------------------
  reg [6:0] rowTimer_r; // oscillator ticks inside one slot
  reg [5:0] scanIdx_r; // current scan slot
  reg [5:0] slots; // slots per frame
  reg [6:0] rowClks; // ticks per slot
  reg [5:0] charRows; // character rows in the frame
  reg [5:0] rowBase; // first panel row shown
  wire slotEnd;
  wire frameEnd;

  // decode of the duty field; unlisted codes fall back to full display
  always @* begin
    case (dutySel)
      `LPD_DUTY_18: begin // two lines
        slots = `LPD_SLOTS_18;
        rowClks = `LPD_ROWCLK_18; // about 73 Hz
      end
      `LPD_DUTY_10: begin // one line
        slots = `LPD_SLOTS_10;
        rowClks = `LPD_ROWCLK_10; // about 74 Hz
      end
      default: begin // four lines at 1/34
        slots = `LPD_SLOTS_34;
        rowClks = `LPD_ROWCLK_34; // about 74 Hz
      end
    endcase
    charRows = slots - 6'd`LPD_ICONS;
    // centering places the shown lines mid-panel
    if (centerEn) begin
      rowBase = (`LPD_PANEL_ROWS - charRows) >> 1;
    end else begin
      rowBase = 6'h00;
    end
  end

  assign slotEnd = oscTick & (rowTimer_r >= rowClks - 7'd1); // shorter slot set mid-slot ends it
  assign frameEnd = slotEnd & (scanIdx_r >= slots - 6'd1); // shorter duty never overruns

  // ----------------------------------------
  // oscillator divider and settle counter
  // ----------------------------------------
  // one clock domain: the oscillator is only an enable pulse here
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      oscDiv_r <= {`LPD_OSC_DIV_W{1'b0}};
      oscTick <= 1'b0;
      oscRun_r <= 1'b1;
      settle_r <= 8'h00;
      oscStable_r <= 1'b0;
    end else begin
      oscTick <= 1'b0;
      if (oscStartCmd) begin // restart is always accepted
        oscRun_r <= 1'b1;
        if (!oscRun_r) begin
          settle_r <= 8'h00;
          oscStable_r <= 1'b0;
        end
      end else if (regWrite && wrAllowed && regAddr == `LPD_A_POWER &&
                   regWrData[`LPD_P_STBY] && !stbyReq) begin
        // entering standby halts the oscillator; sleep leaves it alone
        oscRun_r <= 1'b0;
        oscStable_r <= 1'b0;
      end
      if (oscRun_r) begin
        if (oscDiv_r == OSC_DIV[`LPD_OSC_DIV_W-1:0] - 1'b1) begin
          oscDiv_r <= {`LPD_OSC_DIV_W{1'b0}};
          oscTick <= 1'b1;
        end else begin
          oscDiv_r <= oscDiv_r + 1'b1;
        end
        // host waits for this before clearing standby
        if (oscTick && !oscStable_r) begin
          if (settle_r == `LPD_OSC_SETTLE - 8'h01) begin
            oscStable_r <= 1'b1;
          end
          settle_r <= settle_r + 8'h01;
        end
      end else begin
        oscDiv_r <= {`LPD_OSC_DIV_W{1'b0}};
      end
    end
  end

  // ----------------------------------------
  // frame scan counters
  // ----------------------------------------
  // counters restart at slot zero whenever display is off, so a wake
  // begins a clean frame with the old settings
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rowTimer_r <= 7'h00;
      scanIdx_r <= 6'h00;
    end else if (!dispActive) begin
      rowTimer_r <= 7'h00;
      scanIdx_r <= 6'h00;
    end else if (oscTick) begin
      if (slotEnd) begin
        rowTimer_r <= 7'h00;
        scanIdx_r <= frameEnd ? 6'h00 : scanIdx_r + 6'h01;
      end else begin
        rowTimer_r <= rowTimer_r + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // row and column driver levels
  // ----------------------------------------
  reg [`LPD_ROWS-1:0] rowDrive_nxt;
  reg [`LPD_ROWS-1:0] rowSel_nxt;
  reg [`LPD_ICONS-1:0] iconDrive_nxt;
  reg [`LPD_ICONS-1:0] iconSel_nxt;
  reg [5:0] physRow;
  integer i;

  // driven but unselected is the off level; not driven is ground
  always @* begin
    rowDrive_nxt = {`LPD_ROWS{1'b0}};
    rowSel_nxt = {`LPD_ROWS{1'b0}};
    iconDrive_nxt = {`LPD_ICONS{1'b0}};
    iconSel_nxt = {`LPD_ICONS{1'b0}};
    physRow = rowBase + scanIdx_r;
    if (dispActive) begin
      // rows outside the window stay at the unselected level
      rowDrive_nxt = {`LPD_ROWS{1'b1}};
      iconDrive_nxt = {`LPD_ICONS{1'b1}};
      if (scanIdx_r < charRows) begin
        for (i = 0; i < `LPD_ROWS; i = i + 1) begin
          if (physRow == i[5:0]) begin
            rowSel_nxt[i] = 1'b1;
          end
        end
      end else begin
        iconSel_nxt[scanIdx_r - charRows == 6'h00 ? 0 : 1] = 1'b1;
      end
    end
    // sleep and standby leave every driver grounded
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rowDriveOn <= {`LPD_ROWS{1'b0}};
      rowSelect <= {`LPD_ROWS{1'b0}};
      iconRowDriveOn <= {`LPD_ICONS{1'b0}};
      iconRowSelect <= {`LPD_ICONS{1'b0}};
      columnDriveOn <= 1'b0;
      frameStart <= 1'b0;
    end else begin
      rowDriveOn <= rowDrive_nxt;
      rowSelect <= rowSel_nxt;
      iconRowDriveOn <= iconDrive_nxt;
      iconRowSelect <= iconSel_nxt;
      columnDriveOn <= dispActive;
      frameStart <= frameEnd & dispActive;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // settings are never cleared by a mode change
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_r <= `LPD_CTRL_RST;
      power_r <= `LPD_POWER_RST;
      drive_r <= `LPD_DRIVE_RST;
      keyIrqEn_r <= 1'b0;
      mask_r <= {`LPD_NEV{1'b0}};
    end else if (regWrite) begin
      // key interrupt enable is taken even in standby
      if (regAddr == `LPD_A_KEYEN) begin
        keyIrqEn_r <= regWrData[0];
      end
      if (wrAllowed) begin
        case (regAddr)
          `LPD_A_CTRL: ctrl_r <= {1'b0, regWrData[6:0]};
          `LPD_A_POWER: power_r <= {5'h00, regWrData[2:0]};
          `LPD_A_DRIVE: drive_r <= {1'b0, regWrData[6:0]};
          `LPD_A_MASK: mask_r <= regWrData[`LPD_NEV-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // sticky status, write one to clear
  // ----------------------------------------
  // a new event in the clearing cycle wins over the clear
  always @* begin
    status_nxt = status_r;
    if (regWrite && wrAllowed && regAddr == `LPD_A_STATUS) begin
      status_nxt = status_r & ~regWrData[`LPD_NEV-1:0];
    end
    // key detection works in every mode, standby included
    if (keyHit && keyIrqEn_r) begin
      status_nxt[`LPD_S_KEY] = 1'b1;
    end
    if (frameEnd && dispActive) begin
      status_nxt[`LPD_S_FRAME] = 1'b1;
    end
    if (oscTick && oscRun_r && !oscStable_r && settle_r == `LPD_OSC_SETTLE - 8'h01) begin
      status_nxt[`LPD_S_OSC] = 1'b1;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      status_r <= {`LPD_NEV{1'b0}};
    end else begin
      status_r <= status_nxt;
    end
  end

  // ----------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------
  always @* begin
    rdData_nxt = {`LPD_DATA_W{1'b0}};
    case (regAddr)
      `LPD_A_CTRL: rdData_nxt = ctrl_r;
      `LPD_A_POWER: rdData_nxt = power_r;
      `LPD_A_OSC: rdData_nxt = {6'h00, oscStable_r, oscRun_r};
      `LPD_A_KEYEN: rdData_nxt = {7'h00, keyIrqEn_r};
      `LPD_A_STATUS: rdData_nxt = {5'h00, status_r};
      `LPD_A_MASK: rdData_nxt = {5'h00, mask_r};
      `LPD_A_STATE: begin
        rdData_nxt[1:0] = stbyReq ? `LPD_MODE_STBY :
                          (sleepEff ? `LPD_MODE_SLEEP : `LPD_MODE_RUN);
        rdData_nxt[2] = dispActive;
        rdData_nxt[3] = (dutySel == `LPD_DUTY_18) | (dutySel == `LPD_DUTY_10);
      end
      `LPD_A_DRIVE: rdData_nxt = drive_r;
      default: rdData_nxt = {`LPD_DATA_W{1'b0}}; // unmapped reads zero
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      regRdData <= {`LPD_DATA_W{1'b0}};
      keyIrq_n <= 1'b1;
      irq <= 1'b0;
      keyScanRun <= 1'b0;
      oscRunning <= 1'b0;
      lcdSupplyOn <= 1'b0;
      boostLevel <= 2'h0;
      contrastLevel <= 5'h00;
      biasSelect <= 3'h0;
    end else begin
      regRdData <= regRead ? rdData_nxt : {`LPD_DATA_W{1'b0}};
      keyIrq_n <= ~(status_r[`LPD_S_KEY] & keyIrqEn_r);
      irq <= |(status_r & mask_r);
      // scan runs in sleep, halts with the oscillator in standby
      keyScanRun <= oscRun_r & ~stbyReq;
      oscRunning <= oscRun_r;
      // supply drops only in a low-power mode with the bit cleared
      lcdSupplyOn <= ~((sleepReq | stbyReq) & ~power_r[`LPD_P_SUPPLY]);
      boostLevel <= drive_r[1:0];
      contrastLevel <= drive_r[6:2];
      biasSelect <= ctrl_r[5:3];
    end
  end

endmodule
`default_nettype wire

// >>> lpd_power_ctl_checker.sv
// concurrent checks on the ports of the lcd power-mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpd_power_defs.vh"
module lpd_power_ctl_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic keyHit,
  input wire logic keyIrq_n,
  input wire logic keyScanRun,
  input wire logic oscRunning,
  input wire logic lcdSupplyOn,
  input wire logic columnDriveOn,
  input wire logic [39:0] rowDriveOn,
  input wire logic [39:0] rowSelect,
  input wire logic [1:0] iconRowDriveOn,
  input wire logic [1:0] iconRowSelect,
  input wire logic frameStart
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // power write that is taken: oscillator up, so never refused
  wire pwrWr = regWrite && regAddr == `LPD_A_POWER && oscRunning;
  // every driver output at ground
  wire allOff = !columnDriveOn && rowDriveOn == '0 && iconRowDriveOn == '0;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_low_power_dark: assert property (pwrWr && regWrData[1:0] != 2'b00 |-> ##2 allOff [*4])
    else $error("drivers not grounded in low power");
  chk_sleep_scan_on: assert property (pwrWr && regWrData[1:0] == 2'b01 |->
    ##2 (oscRunning && keyScanRun) [*4]) else $error("sleep stopped oscillator or scan");
  chk_stby_osc_stop: assert property (pwrWr && regWrData[1] |->
    ##2 (!oscRunning && !keyScanRun) [*3]) else $error("standby left oscillator running");
  chk_supply_follow: assert property (pwrWr && regWrData[1:0] != 2'b00 |->
    ##2 lcdSupplyOn == $past(regWrData[2], 2)) else $error("supply not per enable bit");
  chk_wake_display: assert property (pwrWr && regWrData[1:0] == 2'b00 |->
    ##[2:3] columnDriveOn) else $error("display did not resume");
  chk_unselected_rows: assert property (columnDriveOn |-> (&rowDriveOn) && (&iconRowDriveOn))
    else $error("undisplayed row left at ground");
  chk_one_row: assert property ($onehot0({rowSelect, iconRowSelect}) &&
    (rowSelect & ~rowDriveOn) == '0) else $error("row selection not single");
  chk_key_cause: assert property ($fell(keyIrq_n) |->
    $past(keyHit) || $past(keyHit, 2) || $past(keyHit, 3)) else $error("key irq without key");
  // main scenarios reached
  cover property (pwrWr && regWrData[1:0] == 2'b01);
  cover property (pwrWr && regWrData[1]);
  cover property ($fell(keyIrq_n) && !oscRunning);
  cover property (frameStart);
endmodule
bind lpd_power_ctl lpd_power_ctl_checker i_lpd_power_ctl_checker (.clock(clock),
  .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .keyHit(keyHit), .keyIrq_n(keyIrq_n), .keyScanRun(keyScanRun), .oscRunning(oscRunning),
  .lcdSupplyOn(lcdSupplyOn), .columnDriveOn(columnDriveOn), .rowDriveOn(rowDriveOn),
  .rowSelect(rowSelect), .iconRowDriveOn(iconRowDriveOn), .iconRowSelect(iconRowSelect),
  .frameStart(frameStart));
`default_nettype wire

// >>> lpd_key_model.sv
// key matrix stand-in that reports presses to the controller
`timescale 1ns/1ps
`default_nettype none
module lpd_key_model (
  input wire logic clock,
  input wire logic pressReq,
  input wire logic [3:0] holdLen,
  output wire logic keyHit
);
  // ----------------------------------------
  // press timing
  // ----------------------------------------
  logic [3:0] left_r = 4'h0; // cycles of press still to go
  // a press lasts holdLen cycles: 1 is a quick tap, larger a slow finger
  always @(posedge clock) begin
    if (pressReq) begin
      left_r <= holdLen;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end
  assign keyHit = (left_r != 4'h0); // released key reads low
endmodule
`default_nettype wire

// >>> lpd_power_ctl_tb_top.sv
// self-checking bench for the lcd power-mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpd_power_defs.vh"
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module lpd_power_ctl_tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int OSC = 4; // short divide keeps a frame near 2700 cycles
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic pressReq = 1'b0;
  logic [3:0] holdLen = 4'h1;
  logic [7:0] regRdData, rdVal;
  logic keyHit, keyIrq_n, irq, keyScanRun, oscRunning, lcdSupplyOn, columnDriveOn, frameStart;
  logic [39:0] rowDriveOn, rowSelect, seen;
  logic [1:0] iconRowDriveOn, iconRowSelect, boostLevel, icons;
  logic [4:0] contrastLevel;
  logic [2:0] biasSelect;
  int mismatches = 0;
  int total_checks = 0;
  lpd_power_ctl #(.OSC_DIV(OSC)) i_lpd_power_ctl (.clock(clock), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .keyHit(keyHit), .keyIrq_n(keyIrq_n), .irq(irq),
    .keyScanRun(keyScanRun), .oscRunning(oscRunning), .lcdSupplyOn(lcdSupplyOn),
    .columnDriveOn(columnDriveOn), .rowDriveOn(rowDriveOn), .rowSelect(rowSelect),
    .iconRowDriveOn(iconRowDriveOn), .iconRowSelect(iconRowSelect),
    .boostLevel(boostLevel), .contrastLevel(contrastLevel), .biasSelect(biasSelect),
    .frameStart(frameStart));
  lpd_key_model i_lpd_key_model (.clock(clock), .pressReq(pressReq), .holdLen(holdLen),
    .keyHit(keyHit));
  initial forever #5 clock = ~clock;
  // ----------------------------------------
  // bus and helper tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    rdVal = regRdData;
  endtask
  task automatic expRd(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rdVal, e)
  endtask
  task automatic press(input logic [3:0] len);
    @(posedge clock);
    holdLen <= len;
    pressReq <= 1'b1;
    @(posedge clock);
    pressReq <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // gathers selected rows until the next frame pulse, bounded
  task automatic waitFrame(output int n);
    n = 0;
    do begin
      settle(1);
      seen |= rowSelect;
      icons |= iconRowSelect;
      n++;
    end while (frameStart !== 1'b1 && n < 6000);
    if (n >= 6000) mismatches++;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_values;
    expRd(`LPD_A_CTRL, `LPD_CTRL_RST);
    expRd(`LPD_A_POWER, `LPD_POWER_RST);
    expRd(`LPD_A_KEYEN, 8'h00);
    expRd(`LPD_A_MASK, 8'h00);
    expRd(`LPD_A_DRIVE, `LPD_DRIVE_RST);
    expRd(4'hF, 8'h00); // unmapped place reads zero
    wr(`LPD_A_DRIVE, 8'h5E);
  endtask
  // one full frame: lit rows, icon rows, period and bias
  task automatic duty_case(input logic [7:0] ctrl, input int rows, input int base,
                           input int rowClk, input bit doWr);
    int n;
    if (doWr)
      wr(`LPD_A_CTRL, ctrl);
    waitFrame(n);
    seen = '0;
    icons = '0;
    waitFrame(n);
    `CHK(seen, ((40'h1 << rows) - 40'h1) << base)
    `CHK(icons, 2'b11)
    `CHK(n, (rows + 2) * rowClk * OSC)
    `CHK(biasSelect, ctrl[5:3])
  endtask
  task automatic sleep_case;
    wr(`LPD_A_MASK, 8'h01);
    wr(`LPD_A_KEYEN, 8'h01);
    wr(`LPD_A_POWER, 8'h05);
    press(4'h1);
    settle(4);
    `CHK({columnDriveOn, lcdSupplyOn, oscRunning, keyScanRun}, 4'b0111)
    `CHK({keyIrq_n, irq}, 2'b01)
    `CHK({rowDriveOn, iconRowDriveOn}, 42'h0)
    expRd(`LPD_A_STATE, 8'h09); // sleep mode, display off, partial duty
    wr(`LPD_A_MASK, 8'h00);
    settle(1);
    `CHK({keyIrq_n, irq}, 2'b00)
    wr(`LPD_A_STATUS, 8'h01);
    settle(1);
    `CHK(keyIrq_n, 1'b1)
    wr(`LPD_A_KEYEN, 8'h00);
    wr(`LPD_A_POWER, 8'h04);
    settle(3);
    `CHK(columnDriveOn, 1'b1)
  endtask
  task automatic stby_case;
    int n;
    wr(`LPD_A_STATUS, 8'h04); // drop the stale stable flag left from power-up
    wr(`LPD_A_POWER, 8'h03); // sleep and standby together, supply off
    settle(3);
    `CHK({oscRunning, keyScanRun, columnDriveOn, lcdSupplyOn}, 4'b0000)
    `CHK(rowDriveOn, 40'h0)
    wr(`LPD_A_CTRL, 8'h11); // lost: oscillator is halted
    wr(`LPD_A_KEYEN, 8'h01);
    expRd(`LPD_A_CTRL, 8'h22);
    expRd(`LPD_A_KEYEN, 8'h01);
    expRd(`LPD_A_STATE, 8'h0A); // standby wins over sleep
    press(4'h8);
    settle(12);
    `CHK(keyIrq_n, 1'b0)
    wr(`LPD_A_OSC, 8'h01);
    expRd(`LPD_A_OSC, 8'h01); // running again but not yet settled
    n = 0;
    do begin
      rd(`LPD_A_STATUS);
      n++;
    end while (rdVal[2] !== 1'b1 && n < 100);
    `CHK(rdVal[2], 1'b1)
    wr(`LPD_A_STATUS, 8'h05);
    wr(`LPD_A_POWER, 8'h04);
    settle(3);
    `CHK({oscRunning, columnDriveOn, lcdSupplyOn, keyIrq_n}, 4'b1111)
    `CHK({contrastLevel, boostLevel}, 7'h5E)
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    reset_values;
    duty_case(8'h14, 32, 0, `LPD_ROWCLK_34, 1'b1);
    duty_case(8'h62, 16, 8, `LPD_ROWCLK_18, 1'b1);
    duty_case(8'h71, 8, 12, `LPD_ROWCLK_10, 1'b1);
    duty_case(8'h22, 16, 0, `LPD_ROWCLK_18, 1'b1);
    sleep_case;
    stby_case;
    duty_case(8'h22, 16, 0, `LPD_ROWCLK_18, 1'b0);
    give_verdict;
  end
  // all scenarios need about 30000 cycles; the limit allows some slack
  initial begin
    #500_000;
    mismatches++;
    give_verdict;
  end
endmodule
`default_nettype wire
